// File: logic/tdis_pkg.sv
`default_nettype none
package tdis_pkg;
    // Register bus
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam logic [7:0]  CTRL_OFS      = 8'h00;
    localparam logic [7:0]  TS_GRP_OFS    = 8'h04;
    localparam logic [7:0]  KEY_GRP_OFS   = 8'h08;
    localparam logic [7:0]  LIMIT_OFS     = 8'h0C;
    localparam logic [7:0]  TS_STAT_OFS   = 8'h10;
    localparam logic [7:0]  KEY_STAT_OFS  = 8'h14;
    localparam logic [7:0]  PROX_STAT_OFS = 8'h18;
    localparam logic [7:0]  IRQ_STAT_OFS  = 8'h1C;
    localparam logic [7:0]  IRQ_MASK_OFS  = 8'h20;
    // Field positions
    localparam int          KEY_INT_BIT   = 0;
    localparam int          LIM_FW        = 8;
    localparam int          TS_LIM_LSB    = 0;
    localparam int          KEY_LIM_LSB   = 8;
    localparam int          PROX_LIM_LSB  = 16;
    // Interrupt status layout
    localparam int          IRQ_W         = 4;
    localparam int          IRQ_TS        = 0;
    localparam int          IRQ_KEY       = 1;
    localparam int          IRQ_PROX      = 2;
    localparam int          IRQ_REL       = 3;
    // Reset values
    localparam logic [LIM_FW-1:0] LIM_RST  = 8'h00;
    localparam logic [IRQ_W-1:0]  MASK_RST = 4'h0;
endpackage
`default_nettype wire

// File: logic/tdis_core.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// (RULE_01) First object to detect owns the group
// (RULE_02) Group blocks new detections until owner releases
// (RULE_03) An object may join several groups
// (RULE_04) Touchscreen and key array suppress each other
// (RULE_05) Internal suppression: one touched key wins
// (RULE_06) Internal suppression exists only in key array
// (RULE_07) Held touch survives enabling suppression until release
// (RULE_08) Count up on each acquisition above threshold
// (RULE_09) Touch declared when count reaches limit
// (RULE_10) Acquisition below threshold clears the count
// (RULE_11) Groups and internal enable come from config
// (RULE_12) Separate integration limit per touch object
// (RULE_13) Configure several-cycle limit when using suppression
// (RULE_14) Reset clears counts, detections and ownership
module tdis_core #(
    parameter int TS_CH   = 16,
    parameter int KEY_CH  = 8,
    parameter int PROX_CH = 4,
    parameter int NGRP    = 4,
    parameter int CW      = tdis_pkg::LIM_FW
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic [tdis_pkg::ADDR_W-1:0] paddr,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [tdis_pkg::DATA_W-1:0] pwdata,
    output logic      [tdis_pkg::DATA_W-1:0] prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        acq_tick,
    input  wire logic [TS_CH-1:0]            ts_above,
    input  wire logic [KEY_CH-1:0]           key_above,
    input  wire logic [PROX_CH-1:0]          prox_above,
    output logic      [TS_CH-1:0]            ts_touch,
    output logic      [KEY_CH-1:0]           key_touch,
    output logic      [PROX_CH-1:0]          prox_touch,
    output logic                             irq
);
    import tdis_pkg::*;

    localparam int NCH    = TS_CH + KEY_CH + PROX_CH;
    localparam int KEY_LO = TS_CH;
    localparam int KEY_HI = TS_CH + KEY_CH - 1;
    localparam int PX_LO  = TS_CH + KEY_CH;

    typedef struct packed {
        logic [NCH-1:0][CW-1:0] cnt;
        logic [NCH-1:0]         rep;
        logic                   key_int_en;
        logic [NGRP-1:0]        ts_grp;
        logic [NGRP-1:0]        key_grp;
        logic [CW-1:0]          ts_lim;
        logic [CW-1:0]          key_lim;
        logic [CW-1:0]          px_lim;
        logic [IRQ_W-1:0]       irq_stat;
        logic [IRQ_W-1:0]       irq_mask;
        logic [DATA_W-1:0]      prdata;
        logic                   pslverr;
    } tdis_state_t;

    tdis_state_t        st;
    tdis_state_t        next_st;
    logic [NCH-1:0]     above;
    logic [CW-1:0]      ch_lim [NCH];
    logic [NCH-1:0]     raw;
    logic               ts_act;
    logic               key_act;
    logic               shared;
    logic [DATA_W-1:0]  rd;
    logic               hit;
    logic [IRQ_W-1:0]   clr;
    logic [IRQ_W-1:0]   ev;
    logic [CW-1:0]      nlim;

    assign above = {prox_above, key_above, ts_above};

    // Per-channel limit chosen by owning object
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            if (g < KEY_LO) begin : g_ts
                assign ch_lim[g] = st.ts_lim;                          // [RULE_12]
            end else if (g < PX_LO) begin : g_key
                assign ch_lim[g] = st.key_lim;                         // [RULE_12]
            end else begin : g_px
                assign ch_lim[g] = st.px_lim;                          // [RULE_12]
            end

            count_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_10]
                acq_tick && !above[g] |=> st.cnt[g] == '0)
                else $error("count not cleared below threshold");
            count_step_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_08]
                acq_tick && above[g] && (st.cnt[g] < ch_lim[g])
                |=> st.cnt[g] == CW'($past(st.cnt[g]) + 1'b1))
                else $error("count did not step above threshold");
            touch_limit_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_09]
                st.rep[g] |-> (ch_lim[g] != '0) && (st.cnt[g] >= ch_lim[g]))
                else $error("touch reported below limit");
            held_touch_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_07]
                st.rep[g] && !acq_tick && !(psel && penable && pwrite) |=> st.rep[g])
                else $error("held touch dropped without release");
        end
    endgenerate

    always_comb begin
        next_st = st;
        raw     = '0;
        ts_act  = 1'b0;
        key_act = 1'b0;
        rd      = '0;
        hit     = 1'b1;
        clr     = '0;
        ev      = '0;
        nlim    = '0;

        // Register read decode
        case (paddr)
            CTRL_OFS: begin
                rd[KEY_INT_BIT] = st.key_int_en;
            end
            TS_GRP_OFS: begin
                rd[NGRP-1:0] = st.ts_grp;
            end
            KEY_GRP_OFS: begin
                rd[NGRP-1:0] = st.key_grp;
            end
            LIMIT_OFS: begin
                rd[TS_LIM_LSB +: CW]   = st.ts_lim;
                rd[KEY_LIM_LSB +: CW]  = st.key_lim;
                rd[PROX_LIM_LSB +: CW] = st.px_lim;
            end
            TS_STAT_OFS: begin
                rd = DATA_W'(st.rep[TS_CH-1:0]);
            end
            KEY_STAT_OFS: begin
                rd = DATA_W'(st.rep[KEY_HI:KEY_LO]);
            end
            PROX_STAT_OFS: begin
                rd = DATA_W'(st.rep[NCH-1:PX_LO]);
            end
            IRQ_STAT_OFS: begin
                rd[IRQ_W-1:0] = st.irq_stat;
            end
            IRQ_MASK_OFS: begin
                rd[IRQ_W-1:0] = st.irq_mask;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        if (psel && !penable) begin
            next_st.prdata  = rd;
            next_st.pslverr = !hit;
        end

        // Register writes
        if (psel && penable && pwrite && hit) begin
            case (paddr)
                CTRL_OFS: begin
                    next_st.key_int_en = pwdata[KEY_INT_BIT];                   // [RULE_11]
                end
                TS_GRP_OFS: begin
                    next_st.ts_grp = pwdata[NGRP-1:0];                           // [RULE_11]
                end
                KEY_GRP_OFS: begin
                    next_st.key_grp = pwdata[NGRP-1:0];                          // [RULE_11]
                end
                LIMIT_OFS: begin
                    next_st.ts_lim  = pwdata[TS_LIM_LSB +: CW];                  // [RULE_12]
                    next_st.key_lim = pwdata[KEY_LIM_LSB +: CW];                 // [RULE_12]
                    next_st.px_lim  = pwdata[PROX_LIM_LSB +: CW];                // [RULE_12]
                end
                IRQ_STAT_OFS: begin
                    clr = pwdata[IRQ_W-1:0];
                end
                IRQ_MASK_OFS: begin
                    next_st.irq_mask = pwdata[IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // Detection integrator
        for (int i = 0; i < NCH; i++) begin
            if (acq_tick) begin
                if (!above[i]) begin
                    next_st.cnt[i] = '0;                                         // [RULE_10]
                end else if (st.cnt[i] < ch_lim[i]) begin
                    next_st.cnt[i] = CW'(st.cnt[i] + 1'b1);                      // [RULE_08]
                end
            end
            if (i < KEY_LO) begin
                nlim = next_st.ts_lim;
            end else if (i < PX_LO) begin
                nlim = next_st.key_lim;
            end else begin
                nlim = next_st.px_lim;
            end
            raw[i] = (nlim != '0) && (next_st.cnt[i] >= nlim);                   // [RULE_09]
            if (!raw[i]) begin
                next_st.rep[i] = 1'b0;
            end
        end

        // Ownership from touches still held
        for (int i = 0; i < KEY_LO; i++) begin
            ts_act = ts_act | next_st.rep[i];
        end
        for (int i = KEY_LO; i <= KEY_HI; i++) begin
            key_act = key_act | next_st.rep[i];
        end
        shared = |(st.ts_grp & st.key_grp);                                     // [RULE_03]

        // Touchscreen enters unless a grouped key owns; ties go to it
        for (int i = 0; i < KEY_LO; i++) begin
            if (raw[i] && !next_st.rep[i] && !(shared && key_act)) begin         // [RULE_04]
                next_st.rep[i] = 1'b1;                                           // [RULE_01]
            end
        end
        for (int i = 0; i < KEY_LO; i++) begin
            ts_act = ts_act | next_st.rep[i];
        end

        // Keys: group level, then internal, lowest index first
        for (int i = KEY_LO; i <= KEY_HI; i++) begin
            if (raw[i] && !next_st.rep[i] && !(shared && ts_act)                 // [RULE_02]
                    && !(st.key_int_en && key_act)) begin                        // [RULE_05]
                next_st.rep[i] = 1'b1;
                key_act        = 1'b1;
            end
        end

        // Proximity: no suppression of any kind
        for (int i = PX_LO; i < NCH; i++) begin
            next_st.rep[i] = raw[i];                                             // [RULE_06]
        end

        // Sticky events, set wins over clear
        ev[IRQ_TS]   = |(next_st.rep[TS_CH-1:0] & ~st.rep[TS_CH-1:0]);
        ev[IRQ_KEY]  = |(next_st.rep[KEY_HI:KEY_LO] & ~st.rep[KEY_HI:KEY_LO]);
        ev[IRQ_PROX] = |(next_st.rep[NCH-1:PX_LO] & ~st.rep[NCH-1:PX_LO]);
        ev[IRQ_REL]  = |(st.rep & ~next_st.rep);
        next_st.irq_stat = (st.irq_stat & ~clr) | ev;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st            <= '0;                                                 // [RULE_14]
            st.ts_lim     <= LIM_RST;
            st.key_lim    <= LIM_RST;
            st.px_lim     <= LIM_RST;
            st.irq_mask   <= MASK_RST;
        end else begin
            st <= next_st;
        end
    end

    assign prdata     = st.prdata;
    assign pslverr    = st.pslverr;
    assign pready     = 1'b1;
    assign ts_touch   = st.rep[TS_CH-1:0];
    assign key_touch  = st.rep[KEY_HI:KEY_LO];
    assign prox_touch = st.rep[NCH-1:PX_LO];
    assign irq        = |(st.irq_stat & st.irq_mask);

    // Sequences of group ownership
    sequence ts_owns_s;
        shared && (|ts_touch) ##1 (|ts_touch);
    endsequence
    sequence key_owns_s;
        shared && (|key_touch) ##1 (|key_touch);
    endsequence

    key_blocked_a: assert property (@(posedge pclk) disable iff (!presetn)   // [RULE_02]
        ts_owns_s |-> (key_touch & ~$past(key_touch)) == '0)
        else $error("key entered while touchscreen owns group");
    ts_blocked_a: assert property (@(posedge pclk) disable iff (!presetn)    // [RULE_04]
        key_owns_s |-> (ts_touch & ~$past(ts_touch)) == '0)
        else $error("touchscreen entered while key owns group");
    single_key_a: assert property (@(posedge pclk) disable iff (!presetn)    // [RULE_05]
        st.key_int_en && (|key_touch) |=> $countones(key_touch) <= $countones($past(key_touch)))
        else $error("second key entered under internal suppression");
    tie_first_a: assert property (@(posedge pclk) disable iff (!presetn)     // [RULE_01]
        shared && $rose(|ts_touch) |-> (key_touch & ~$past(key_touch)) == '0)
        else $error("key and touchscreen both entered one group");
    touch_event_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(|ts_touch) |-> st.irq_stat[IRQ_TS])
        else $error("touch event not flagged");
    key_event_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(|key_touch) |-> st.irq_stat[IRQ_KEY])
        else $error("key event not flagged");
    release_event_a: assert property (@(posedge pclk) disable iff (!presetn)
        (|($past(st.rep) & ~st.rep)) |-> st.irq_stat[IRQ_REL])
        else $error("release event not flagged");

endmodule // tdis_core
`default_nettype wire

// File: verif/test_touch_detect_integrate_suppress.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
    $display("mismatch %s expected %h seen %h", nm, e, g); miscompares++; end end
module test_touch_detect_integrate_suppress;
    import tdis_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        acq_tick = 1'b0;
    logic [15:0] ts_above = 16'h0;
    logic [7:0]  key_above = 8'h0;
    logic [3:0]  prox_above = 4'h0;
    logic [15:0] ts_touch;
    logic [7:0]  key_touch;
    logic [3:0]  prox_touch;
    logic        irq;
    logic [31:0] rd;
    logic        er;
    int          miscompares = 0;
    int          comparisons = 0;

    tdis_core u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .acq_tick(acq_tick), .ts_above(ts_above),
        .key_above(key_above), .prox_above(prox_above), .ts_touch(ts_touch),
        .key_touch(key_touch), .prox_touch(prox_touch), .irq(irq));

    always #4 pclk = ~pclk;

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            miscompares++;
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task automatic tick(input logic [15:0] t, input logic [7:0] k, input logic [3:0] p);
        @(posedge pclk);
        acq_tick   <= 1'b1;
        ts_above   <= t;
        key_above  <= k;
        prox_above <= p;
        @(posedge pclk);
        acq_tick <= 1'b0;
        @(posedge pclk);
        #1;
    endtask

    task automatic results;
        if (miscompares == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic t_reset;
        #1;
        `CHK("touch after reset", 29'h0, {ts_touch, key_touch, prox_touch, irq})
        `CHK("pready", 1'b1, pready)
        apb(1'b0, LIMIT_OFS, 32'h0);
        `CHK("limit reset", 32'h0, rd)
        apb(1'b0, IRQ_MASK_OFS, 32'h0);
        `CHK("mask reset", 32'h0, rd)
        apb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped err", 1'b1, er)
        `CHK("unmapped data", 32'h0, rd)
    endtask

    task automatic t_integrate;
        apb(1'b1, LIMIT_OFS, 32'h0001_0203);
        apb(1'b1, IRQ_STAT_OFS, 32'hF);
        tick(16'h0001, 8'h01, 4'h1);
        `CHK("prox limit 1", 4'h1, prox_touch)
        tick(16'h0001, 8'h01, 4'h1);
        `CHK("key limit 2", 8'h01, key_touch)
        `CHK("ts below limit", 16'h0, ts_touch)
        tick(16'h0000, 8'h01, 4'h1);
        tick(16'h0001, 8'h01, 4'h1);
        tick(16'h0001, 8'h01, 4'h1);
        `CHK("ts restarted", 16'h0, ts_touch)
        tick(16'h0001, 8'h01, 4'h1);
        `CHK("ts limit 3", 16'h0001, ts_touch)
        apb(1'b0, IRQ_STAT_OFS, 32'h0);
        `CHK("irq status", 4'h7, rd[IRQ_W-1:0])
        `CHK("irq masked", 1'b0, irq)
        apb(1'b1, IRQ_MASK_OFS, 32'h4);
        `CHK("irq unmasked", 1'b1, irq)
        apb(1'b1, IRQ_STAT_OFS, 32'h4);
        `CHK("irq cleared", 1'b0, irq)
        tick(16'h0, 8'h0, 4'h0);
        `CHK("all released", 28'h0, {ts_touch, key_touch, prox_touch})
        apb(1'b0, IRQ_STAT_OFS, 32'h0);
        `CHK("release event", 1'b1, rd[IRQ_REL])
        apb(1'b1, IRQ_MASK_OFS, 32'h0);
    endtask

    task automatic t_group;
        apb(1'b1, LIMIT_OFS, 32'h0001_0202);
        apb(1'b1, TS_GRP_OFS, 32'h3);
        apb(1'b1, KEY_GRP_OFS, 32'h2);
        tick(16'h0001, 8'h00, 4'h0);
        tick(16'h0001, 8'h00, 4'h0);
        tick(16'h0001, 8'h01, 4'h0);
        tick(16'h0001, 8'h01, 4'h0);
        `CHK("key blocked by ts", 8'h00, key_touch)
        `CHK("ts owner kept", 16'h0001, ts_touch)
        tick(16'h0000, 8'h01, 4'h0);
        `CHK("key after release", 8'h01, key_touch)
        tick(16'h0001, 8'h01, 4'h0);
        tick(16'h0001, 8'h01, 4'h0);
        `CHK("ts blocked by key", 16'h0000, ts_touch)
        tick(16'h0, 8'h0, 4'h0);
        apb(1'b1, LIMIT_OFS, 32'h0001_0101);
        apb(1'b1, TS_GRP_OFS, 32'h0);
        apb(1'b1, KEY_GRP_OFS, 32'h0);
    endtask

    task automatic t_internal;
        apb(1'b1, CTRL_OFS, 32'h1);
        tick(16'h0003, 8'h09, 4'h0);
        `CHK("one key wins", 8'h01, key_touch)
        `CHK("ts multitouch", 16'h0003, ts_touch)
        apb(1'b0, KEY_STAT_OFS, 32'h0);
        `CHK("key status", 32'h1, rd)
        tick(16'h0, 8'h0, 4'h0);
        apb(1'b1, CTRL_OFS, 32'h0);
    endtask

    task automatic t_late_enable;
        tick(16'h0, 8'h03, 4'h0);
        `CHK("both keys", 8'h03, key_touch)
        apb(1'b1, CTRL_OFS, 32'h1);
        tick(16'h0, 8'h03, 4'h0);
        `CHK("held kept", 8'h03, key_touch)
        tick(16'h0, 8'h01, 4'h0);
        tick(16'h0, 8'h03, 4'h0);
        `CHK("then suppressed", 8'h01, key_touch)
        tick(16'h0, 8'h0, 4'h0);
    endtask

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_integrate();
        t_group();
        t_internal();
        t_late_enable();
        results();
    end

    initial begin
        #200000;
        miscompares++;
        results();
    end
endmodule // test_touch_detect_integrate_suppress
`default_nettype wire
